// ==== hw/uea_top.sv ====
// Serial port with framing-error detection and automatic address recognition.
// Behaviour
// - Modes 1 to 3 are full duplex, separate transmit and receive baud rates.
// - Framing errors are checked only in modes 1, 2 and 3.
// - frame_error_select in power_control_reg turns framing-error checking on.
// - With checking on, a bad stop bit sets frame_error_flag.
// - frame_error_flag clears only by software write or reset.
// - A later good stop bit never clears frame_error_flag.
// - With checking on, receive_done_flag rises at the stop bit.
// - multiproc_enable switches automatic address recognition on.
// - With recognition on, receive_done_flag rises only on a matching address.
// - Mode 1 recognition uses the stop bit as ninth bit; needs match and stop.
// - Both the given address and the broadcast address are answered.
// - In mode 0 multiproc_enable does nothing.
// - Given address is slave_address_reg with mask zeros as don't-cares.
// - Broadcast address is address OR mask, zeros being don't-cares.
// - Address and mask reset to zero, so any address is accepted.
// - Bit 7 of serial_control_reg is frame_error_flag or serial_mode_bit0.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uea_top #(
  parameter logic [15:0] RST_DIV = uea_pkg::UEA_RST_DIV
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uea_pkg::UEA_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line.
  input wire logic rxd,
  output logic txd,
  // Interrupt.
  output logic irq
);
  import uea_pkg::*;

  uea_core_regs_t state_ff;
  uea_core_regs_t nxt_state;
  uea_rx_frame_t rx_frame;
  logic rx_data_pulse;
  logic rx_stop_pulse;
  logic [1:0] mode;
  logic rx_tick;
  logic tx_tick;
  logic wr_access;
  logic rd_setup;
  logic addr_hit;
  logic given_hit;
  logic bcast_hit;
  logic addr_match;
  logic [7:0] bcast;
  logic mp_active;
  logic fe_check;
  logic ri_event;
  logic accept;
  logic sc_write;
  logic [7:0] sc_read;

  // Mode and decoded controls.
  assign mode = {state_ff.sm0, state_ff.serial_control_reg[UEA_SC_SM1]};
  assign mp_active = state_ff.serial_control_reg[UEA_SC_MP_EN] && (mode != UEA_MODE0);
  assign fe_check = state_ff.fe_sel && (mode != UEA_MODE0);

  // Independent baud tick generators for each direction.
  assign rx_tick = (state_ff.rx_cnt == state_ff.rx_div);
  assign tx_tick = (state_ff.tx_cnt == state_ff.tx_div);

  // Address recognition against the given and the broadcast address.
  assign given_hit = ((rx_frame.data ^ state_ff.slave_address_reg) & state_ff.slave_address_mask) == 8'h00;
  assign bcast = state_ff.slave_address_reg | state_ff.slave_address_mask;
  assign bcast_hit = (rx_frame.data & bcast) == bcast;
  assign addr_match = given_hit || bcast_hit;

  // The receive-done moment moves to the stop bit when checking is on.
  assign ri_event = (state_ff.fe_sel || mode == UEA_MODE1) ? rx_stop_pulse : rx_data_pulse;

  // A frame is accepted while the receive-done flag is clear, unless recognition filters it out.
  always_comb
  begin
    accept = !state_ff.serial_control_reg[UEA_SC_RI];
    if (mp_active)
    begin
      if (mode == UEA_MODE1)
      begin
        accept = accept && rx_frame.stop_ok && addr_match;
      end
      else
      begin
        accept = accept && rx_frame.ninth && addr_match;
      end
    end
  end

  // APB decode: zero-wait slave, error on unmapped offsets.
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign sc_write = wr_access && (paddr == UEA_OFS_SERIAL_CTRL);
  always_comb
  begin
    unique case (paddr)
      UEA_OFS_SERIAL_CTRL, UEA_OFS_POWER_CTRL, UEA_OFS_SLAVE_ADDR, UEA_OFS_SLAVE_MASK,
      UEA_OFS_RX_DATA, UEA_OFS_TX_DATA, UEA_OFS_RX_DIV, UEA_OFS_TX_DIV,
      UEA_OFS_IRQ_STAT, UEA_OFS_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // Bit 7 of the control register shows the error flag or the mode bit.
  assign sc_read = {state_ff.fe_sel ? state_ff.fe : state_ff.sm0, state_ff.serial_control_reg};

  // Receiver engine.
  uea_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rx_en(state_ff.serial_control_reg[UEA_SC_REN] && (mode != UEA_MODE0)),
    .nine_bit(mode[1]),
    .tick(rx_tick),
    .rxd(rxd),
    .frame(rx_frame),
    .data_pulse(rx_data_pulse),
    .stop_pulse(rx_stop_pulse)
  );

  // Next state: software writes first, hardware events after, so sets win.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rx_cnt = rx_tick ? 16'h0000 : 16'(state_ff.rx_cnt + 16'h0001);
    nxt_state.tx_cnt = tx_tick ? 16'h0000 : 16'(state_ff.tx_cnt + 16'h0001);

    // Register reads are captured in the setup phase.
    if (rd_setup)
    begin
      unique case (paddr)
        UEA_OFS_SERIAL_CTRL: nxt_state.prdata = {24'h00_0000, sc_read};
        UEA_OFS_POWER_CTRL: nxt_state.prdata = 32'(state_ff.fe_sel) << UEA_PC_FE_SEL;
        UEA_OFS_SLAVE_ADDR: nxt_state.prdata = {24'h00_0000, state_ff.slave_address_reg};
        UEA_OFS_SLAVE_MASK: nxt_state.prdata = {24'h00_0000, state_ff.slave_address_mask};
        UEA_OFS_RX_DATA: nxt_state.prdata = {24'h00_0000, state_ff.rx_buf};
        UEA_OFS_RX_DIV: nxt_state.prdata = {16'h0000, state_ff.rx_div};
        UEA_OFS_TX_DIV: nxt_state.prdata = {16'h0000, state_ff.tx_div};
        UEA_OFS_IRQ_STAT: nxt_state.prdata = {29'h0000_0000, state_ff.irq_stat};
        UEA_OFS_IRQ_MASK: nxt_state.prdata = {29'h0000_0000, state_ff.irq_mask};
        default: nxt_state.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes take effect in the access phase.
    if (wr_access)
    begin
      unique case (paddr)
        UEA_OFS_SERIAL_CTRL:
        begin
          nxt_state.serial_control_reg = pwdata[6:0];
          if (state_ff.fe_sel)
          begin
            nxt_state.fe = pwdata[UEA_SC_FE_SM0];
          end
          else
          begin
            nxt_state.sm0 = pwdata[UEA_SC_FE_SM0];
          end
        end
        UEA_OFS_POWER_CTRL: nxt_state.fe_sel = pwdata[UEA_PC_FE_SEL];
        UEA_OFS_SLAVE_ADDR: nxt_state.slave_address_reg = pwdata[7:0];
        UEA_OFS_SLAVE_MASK: nxt_state.slave_address_mask = pwdata[7:0];
        UEA_OFS_RX_DIV: nxt_state.rx_div = pwdata[15:0];
        UEA_OFS_TX_DIV: nxt_state.tx_div = pwdata[15:0];
        UEA_OFS_IRQ_STAT: nxt_state.irq_stat = state_ff.irq_stat & ~pwdata[UEA_IRQ_W-1:0];
        UEA_OFS_IRQ_MASK: nxt_state.irq_mask = pwdata[UEA_IRQ_W-1:0];
        UEA_OFS_TX_DATA:
        begin
          // A write while a frame is going out, or in mode 0, is dropped.
          if (state_ff.tx_st == UEA_BIT_IDLE && mode != UEA_MODE0)
          begin
            nxt_state.tx_shift = pwdata[7:0];
            nxt_state.tx_ninth = state_ff.serial_control_reg[UEA_SC_TB8];
            nxt_state.tx_st = UEA_BIT_START;
            nxt_state.tx_sub = 4'h0;
            nxt_state.txd = 1'b0;
            nxt_state.tx_cnt = 16'h0000;
          end
        end
        default:
        begin
          nxt_state.prdata = state_ff.prdata;
        end
      endcase
    end

    // Transmitter: sixteen ticks per bit, finished flag at the stop bit.
    if (tx_tick && state_ff.tx_st != UEA_BIT_IDLE)
    begin
      nxt_state.tx_sub = state_ff.tx_sub + 4'h1;
      if (state_ff.tx_sub == UEA_LAST_SUB)
      begin
        unique case (state_ff.tx_st)
          UEA_BIT_START:
          begin
            nxt_state.tx_st = UEA_BIT_DATA;
            nxt_state.tx_bit = 4'h0;
            nxt_state.txd = state_ff.tx_shift[0];
            nxt_state.tx_shift = {1'b0, state_ff.tx_shift[7:1]};
          end
          UEA_BIT_DATA:
          begin
            if (state_ff.tx_bit == UEA_LAST_DATA_BIT)
            begin
              nxt_state.tx_st = mode[1] ? UEA_BIT_NINTH : UEA_BIT_STOP;
              nxt_state.txd = mode[1] ? state_ff.tx_ninth : 1'b1;
              nxt_state.serial_control_reg[UEA_SC_TI] = state_ff.serial_control_reg[UEA_SC_TI] || !mode[1];
              nxt_state.irq_stat[UEA_IRQ_TX] = state_ff.irq_stat[UEA_IRQ_TX] || !mode[1];
            end
            else
            begin
              nxt_state.tx_bit = state_ff.tx_bit + 4'h1;
              nxt_state.txd = state_ff.tx_shift[0];
              nxt_state.tx_shift = {1'b0, state_ff.tx_shift[7:1]};
            end
          end
          UEA_BIT_NINTH:
          begin
            nxt_state.tx_st = UEA_BIT_STOP;
            nxt_state.txd = 1'b1;
            nxt_state.serial_control_reg[UEA_SC_TI] = 1'b1;
            nxt_state.irq_stat[UEA_IRQ_TX] = 1'b1;
          end
          default:
          begin
            nxt_state.tx_st = UEA_BIT_IDLE;
            nxt_state.txd = 1'b1;
          end
        endcase
      end
    end

    // Accepted frame: load buffer, ninth bit and receive-done flag.
    if (ri_event && accept)
    begin
      nxt_state.rx_buf = rx_frame.data;
      nxt_state.serial_control_reg[UEA_SC_RB8] = (mode == UEA_MODE1) ? rx_frame.stop_ok : rx_frame.ninth;
      nxt_state.serial_control_reg[UEA_SC_RI] = 1'b1;
      nxt_state.irq_stat[UEA_IRQ_RX] = 1'b1;
    end

    // Bad stop bit: sticky error, never cleared by a good frame.
    if (rx_stop_pulse && fe_check && !rx_frame.stop_ok)
    begin
      nxt_state.fe = 1'b1;
      nxt_state.irq_stat[UEA_IRQ_FE] = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '{slave_address_reg: UEA_RST_BYTE, slave_address_mask: UEA_RST_BYTE, rx_div: RST_DIV, tx_div: RST_DIV,
                    tx_st: UEA_BIT_IDLE, txd: 1'b1, default: '0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs.
  assign prdata = state_ff.prdata;
  assign txd = state_ff.txd;
  assign irq = |(state_ff.irq_stat & state_ff.irq_mask);

  // Checks on the documented behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_bad_stop;
    rx_stop_pulse && fe_check && !rx_frame.stop_ok;
  endsequence
  sequence s_ctrl_read;
    rd_setup && (paddr == UEA_OFS_SERIAL_CTRL);
  endsequence

  a_apb_zero_wait: assert property (s_setup ##1 s_access |-> pready)
    else $error("APB access not completed in first access cycle");
  a_fe_sets: assert property (s_bad_stop |=> state_ff.fe)
    else $error("Bad stop bit did not set the error flag");
  a_fe_sticky: assert property (state_ff.fe && !sc_write |=> state_ff.fe)
    else $error("Error flag dropped without a software write");
  a_fe_good_stop: assert property (state_ff.fe && rx_stop_pulse && rx_frame.stop_ok |=> state_ff.fe)
    else $error("Good stop bit cleared the error flag");
  a_fe_mode_zero: assert property (mode == UEA_MODE0 && !state_ff.fe && !sc_write |=> !state_ff.fe)
    else $error("Error flag set in mode 0");
  a_ri_at_stop: assert property (state_ff.fe_sel && $rose(state_ff.serial_control_reg[UEA_SC_RI]) && !$past(sc_write)
                                 |-> $past(rx_stop_pulse))
    else $error("Receive done not raised at the stop bit");
  a_ri_addr_match: assert property (mp_active && ri_event && !addr_match
                                    |=> !$rose(state_ff.serial_control_reg[UEA_SC_RI]) || $past(sc_write))
    else $error("Receive done raised on a foreign address");
  a_mode1_stop: assert property (mp_active && mode == UEA_MODE1 && rx_stop_pulse && !rx_frame.stop_ok
                                 && !sc_write |=> $stable(state_ff.serial_control_reg[UEA_SC_RI]))
    else $error("Mode 1 frame with bad stop bit was accepted");
  a_reset_any_addr: assert property (state_ff.slave_address_reg == 8'h00 && state_ff.slave_address_mask == 8'h00 |-> addr_match)
    else $error("Cleared address registers did not accept every address");
  a_bcast_hit: assert property ((rx_frame.data | state_ff.slave_address_reg | state_ff.slave_address_mask) == rx_frame.data
                                |-> addr_match)
    else $error("Broadcast address not recognised");
  a_ninth_zero: assert property (mp_active && mode[1] && ri_event && !rx_frame.ninth && !sc_write
                                 |=> $stable(state_ff.serial_control_reg[UEA_SC_RI]))
    else $error("Data frame accepted while recognition active");

  // Further checks: error flag quiet when off, mode 0, interrupt request, shared bit 7, exact match.
  a_fe_off_quiet: assert property (!state_ff.fe_sel && !state_ff.fe && !sc_write |=> !state_ff.fe)
    else $error("Error flag set while checking was off");
  a_ri_mode_zero: assert property (mode == UEA_MODE0 && !rx_data_pulse && !rx_stop_pulse && !sc_write
                                   |=> $stable(state_ff.serial_control_reg[UEA_SC_RI]))
    else $error("Receive done changed in mode 0");
  a_ri_irq_set: assert property (ri_event && accept |=> state_ff.irq_stat[UEA_IRQ_RX])
    else $error("Accepted frame did not request an interrupt");
  a_ri_data_bit: assert property (!state_ff.fe_sel && mode[1] && $rose(state_ff.serial_control_reg[UEA_SC_RI])
                                  && !$past(sc_write) |-> $past(rx_data_pulse))
    else $error("Receive done not raised at the last data bit");
  a_bit7_error: assert property (s_ctrl_read ##0 state_ff.fe_sel |=> prdata[7] == $past(state_ff.fe))
    else $error("Bit 7 did not show the error flag");
  a_bit7_mode: assert property (s_ctrl_read ##0 !state_ff.fe_sel |=> prdata[7] == $past(state_ff.sm0))
    else $error("Bit 7 did not show the mode bit");
  a_given_exact: assert property (state_ff.slave_address_mask == 8'hFF && rx_frame.data != state_ff.slave_address_reg
                                  |-> !given_hit)
    else $error("Full mask accepted a different address");

endmodule
`default_nettype wire

// ==== include/uea_pkg.sv ====
// Package of constants and types shared by the enhanced serial receiver block.
package uea_pkg;

  // Register offsets, byte addresses on the APB port.
  localparam int unsigned UEA_AW = 8;
  localparam logic [7:0] UEA_OFS_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] UEA_OFS_POWER_CTRL = 8'h04;
  localparam logic [7:0] UEA_OFS_SLAVE_ADDR = 8'h08;
  localparam logic [7:0] UEA_OFS_SLAVE_MASK = 8'h0C;
  localparam logic [7:0] UEA_OFS_RX_DATA = 8'h10;
  localparam logic [7:0] UEA_OFS_TX_DATA = 8'h14;
  localparam logic [7:0] UEA_OFS_RX_DIV = 8'h18;
  localparam logic [7:0] UEA_OFS_TX_DIV = 8'h1C;
  localparam logic [7:0] UEA_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] UEA_OFS_IRQ_MASK = 8'h24;

  // Bit positions in serial_control_reg.
  localparam int unsigned UEA_SC_FE_SM0 = 7;
  localparam int unsigned UEA_SC_SM1 = 6;
  localparam int unsigned UEA_SC_MP_EN = 5;
  localparam int unsigned UEA_SC_REN = 4;
  localparam int unsigned UEA_SC_TB8 = 3;
  localparam int unsigned UEA_SC_RB8 = 2;
  localparam int unsigned UEA_SC_TI = 1;
  localparam int unsigned UEA_SC_RI = 0;

  // Bit position of frame_error_select in power_control_reg.
  localparam int unsigned UEA_PC_FE_SEL = 6;

  // Interrupt status and mask bit positions.
  localparam int unsigned UEA_IRQ_RX = 0;
  localparam int unsigned UEA_IRQ_TX = 1;
  localparam int unsigned UEA_IRQ_FE = 2;
  localparam int unsigned UEA_IRQ_W = 3;

  // Values after reset.
  localparam logic [7:0] UEA_RST_BYTE = 8'h00;
  localparam logic [15:0] UEA_RST_DIV = 16'h0040;

  // Oversampling: sample point and last tick of a bit, and index of the last data bit.
  localparam logic [3:0] UEA_MID_SUB = 4'h7;
  localparam logic [3:0] UEA_LAST_SUB = 4'hF;
  localparam logic [3:0] UEA_LAST_DATA_BIT = 4'h7;

  // Serial port modes as {serial_mode_bit0, mode bit 1}.
  localparam logic [1:0] UEA_MODE0 = 2'h0;
  localparam logic [1:0] UEA_MODE1 = 2'h1;

  // One-hot bit sequencer states, used by both directions.
  typedef enum logic [4:0] {
    UEA_BIT_IDLE = 5'h01,
    UEA_BIT_START = 5'h02,
    UEA_BIT_DATA = 5'h04,
    UEA_BIT_NINTH = 5'h08,
    UEA_BIT_STOP = 5'h10
  } uea_bit_state_t;

  // A received frame as handed from the receiver to the register core.
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } uea_rx_frame_t;

  // State of the receiver engine.
  typedef struct packed {
    uea_bit_state_t st;
    logic [3:0] sub;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic rxd_prev;
    logic data_pulse;
    logic stop_pulse;
    uea_rx_frame_t frame;
  } uea_rx_regs_t;

  // State of the register core and transmitter.
  typedef struct packed {
    logic sm0;
    logic fe;
    logic fe_sel;
    logic [6:0] serial_control_reg;
    logic [7:0] slave_address_reg;
    logic [7:0] slave_address_mask;
    logic [7:0] rx_buf;
    logic [15:0] rx_div;
    logic [15:0] tx_div;
    logic [15:0] rx_cnt;
    logic [15:0] tx_cnt;
    uea_bit_state_t tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_ninth;
    logic txd;
    logic [UEA_IRQ_W-1:0] irq_stat;
    logic [UEA_IRQ_W-1:0] irq_mask;
    logic [31:0] prdata;
  } uea_core_regs_t;

endpackage

// ==== hw/uea_rx.sv ====
// Receive bit engine: start detection, mid-bit sampling, frame and stop reporting.
`timescale 1ns/1ps
`default_nettype none
module uea_rx (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic rx_en,
  input wire logic nine_bit,
  input wire logic tick,
  // Serial input.
  input wire logic rxd,
  // Frame out.
  output uea_pkg::uea_rx_frame_t frame,
  output logic data_pulse,
  output logic stop_pulse
);
  import uea_pkg::*;

  uea_rx_regs_t rx_ff;
  uea_rx_regs_t nxt_rx;

  // Next-state logic: samples each bit at the middle of sixteen ticks.
  always_comb
  begin
    nxt_rx = rx_ff;
    nxt_rx.rxd_prev = rxd;
    nxt_rx.data_pulse = 1'b0;
    nxt_rx.stop_pulse = 1'b0;
    if (!rx_en)
    begin
      nxt_rx.st = UEA_BIT_IDLE;
    end
    else if (rx_ff.st == UEA_BIT_IDLE)
    begin
      // A falling edge on the line opens a frame.
      if (rx_ff.rxd_prev && !rxd)
      begin
        nxt_rx.st = UEA_BIT_START;
        nxt_rx.sub = 4'h0;
      end
    end
    else if (tick)
    begin
      nxt_rx.sub = rx_ff.sub + 4'h1;
      if (rx_ff.sub == UEA_MID_SUB)
      begin
        unique case (rx_ff.st)
          UEA_BIT_START:
          begin
            // A start bit that is high again at mid-bit was a glitch.
            nxt_rx.st = rxd ? UEA_BIT_IDLE : UEA_BIT_DATA;
            nxt_rx.bitn = 4'h0;
          end
          UEA_BIT_DATA:
          begin
            nxt_rx.shift = {rxd, rx_ff.shift[7:1]};
            nxt_rx.bitn = rx_ff.bitn + 4'h1;
            if (rx_ff.bitn == UEA_LAST_DATA_BIT)
            begin
              nxt_rx.frame.data = {rxd, rx_ff.shift[7:1]};
              nxt_rx.frame.ninth = 1'b0;
              nxt_rx.st = nine_bit ? UEA_BIT_NINTH : UEA_BIT_STOP;
              nxt_rx.data_pulse = !nine_bit;
            end
          end
          UEA_BIT_NINTH:
          begin
            nxt_rx.frame.ninth = rxd;
            nxt_rx.data_pulse = 1'b1;
            nxt_rx.st = UEA_BIT_STOP;
          end
          UEA_BIT_STOP:
          begin
            nxt_rx.frame.stop_ok = rxd;
            nxt_rx.stop_pulse = 1'b1;
            nxt_rx.st = UEA_BIT_IDLE;
          end
          default:
          begin
            nxt_rx.st = UEA_BIT_IDLE;
          end
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_ff <= '{st: UEA_BIT_IDLE, rxd_prev: 1'b1, default: '0};
    end
    else
    begin
      rx_ff <= nxt_rx;
    end
  end

  // Outputs straight from the state register.
  assign frame = rx_ff.frame;
  assign data_pulse = rx_ff.data_pulse;
  assign stop_pulse = rx_ff.stop_pulse;

endmodule
`default_nettype wire

// ==== tb/uea_node.sv ====
// Behavioural remote serial node that drives frames onto the device receive line.
`timescale 1ns/1ps
`default_nettype none
module uea_node #(
  parameter int BT = 32
) (
  // Clock.
  input wire logic pclk,
  // Serial line towards the device.
  output logic rxd
);
  // The line idles high between frames.
  initial rxd = 1'b1;

  // Sends start, eight data bits LSB first, an optional ninth bit, then the stop level.
  // Every level is held for exactly BT clock cycles and changed just after an edge.
  task automatic send(input logic [7:0] d, input logic nb, input logic b9, input logic stp);
    logic [10:0] f;
    f = nb ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (BT) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BT) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/uea_top_tb.sv ====
// Self-checking testbench for the enhanced serial receiver block.
`timescale 1ns/1ps
`default_nettype none
module uea_top_tb;
  import uea_pkg::*;
  // A small divisor keeps each bit at 32 clock cycles.
  localparam logic [15:0] DIV = 16'h0001;
  localparam int BT = 16 * (int'(DIV) + 1);
  // Rows: control, address, mask, data, ninth used, ninth, stop, receive expected.
  localparam logic [35:0] TBL [0:8] = '{
    {8'hF0, 8'h00, 8'h00, 8'h33, 4'hF},
    {8'hF0, 8'h56, 8'hFC, 8'h57, 4'hF},
    {8'hF0, 8'h56, 8'hFC, 8'hFE, 4'hF},
    {8'hF0, 8'h56, 8'hFC, 8'h52, 4'hE},
    {8'hF0, 8'h56, 8'hFC, 8'h56, 4'hA},
    {8'hD0, 8'h56, 8'hFC, 8'h52, 4'hF},
    {8'h70, 8'h56, 8'hFF, 8'h56, 4'h3},
    {8'h70, 8'h56, 8'hFF, 8'h56, 4'h0},
    {8'h70, 8'h56, 8'hFF, 8'h57, 4'h2}
  };
  logic pclk, presetn, psel, penable, pwrite, rxd, txd, irq, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] e;
  int miscompares, n_compared, c;

  // Device under test and the remote node on its receive line.
  uea_top #(.RST_DIV(DIV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  uea_node #(.BT(BT)) node_u (.pclk(pclk), .rxd(rxd));

  // Free-running 10 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16)
    begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares the masked value.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd & m, x);
  endtask

  // Lets the edge's updates settle, then compares the interrupt line.
  task automatic ichk(input logic x);
    #1;
    chk(32'(irq), 32'(x));
  endtask

  // Times a mode 3 frame from its start to the receive interrupt.
  task automatic timed(input logic fsel);
    apb(1'b1, UEA_OFS_POWER_CTRL, 32'h0);
    apb(1'b1, UEA_OFS_SERIAL_CTRL, 32'hD0);
    apb(1'b1, UEA_OFS_IRQ_STAT, 32'h7);
    apb(1'b1, UEA_OFS_POWER_CTRL, {25'h0, fsel, 6'h0});
    c = 0;
    fork
      node_u.send(8'h6B, 1'b1, 1'b1, 1'b1);
      while (irq !== 1'b1 && c < 20 * BT)
      begin
        @(posedge pclk);
        c++;
      end
    join
    chk(32'(c >= 10 * BT), 32'(fsel));
    chk(32'(c < 20 * BT), 32'h1);
  endtask

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped offset.
    rchk(UEA_OFS_SLAVE_ADDR, 32'hFF, 32'h0);
    rchk(UEA_OFS_SLAVE_MASK, 32'hFF, 32'h0);
    rchk(UEA_OFS_SERIAL_CTRL, 32'hFF, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(err), 32'h1);
    // Plain mode 1 reception, the interrupt path and a transmit start.
    apb(1'b1, UEA_OFS_SERIAL_CTRL, 32'h50);
    node_u.send(8'hA5, 1'b0, 1'b0, 1'b1);
    rchk(UEA_OFS_SERIAL_CTRL, 32'hFF, 32'h55);
    rchk(UEA_OFS_RX_DATA, 32'hFF, 32'hA5);
    ichk(1'b0);
    apb(1'b1, UEA_OFS_IRQ_MASK, 32'h1);
    ichk(1'b1);
    apb(1'b1, UEA_OFS_IRQ_STAT, 32'h1);
    ichk(1'b0);
    apb(1'b1, UEA_OFS_TX_DATA, 32'h5A);
    c = 0;
    while (txd !== 1'b0 && c < 4)
    begin
      @(posedge pclk);
      c++;
    end
    chk(32'(txd), 32'h0);
    apb(1'b1, UEA_OFS_SERIAL_CTRL, 32'h50);
    // Framing error: sticky flag and the shared bit 7.
    apb(1'b1, UEA_OFS_POWER_CTRL, 32'h40);
    node_u.send(8'h3C, 1'b0, 1'b0, 1'b0);
    rchk(UEA_OFS_SERIAL_CTRL, 32'h80, 32'h80);
    apb(1'b1, UEA_OFS_SERIAL_CTRL, 32'hD0);
    node_u.send(8'h11, 1'b0, 1'b0, 1'b1);
    rchk(UEA_OFS_SERIAL_CTRL, 32'h80, 32'h80);
    apb(1'b1, UEA_OFS_POWER_CTRL, 32'h0);
    rchk(UEA_OFS_SERIAL_CTRL, 32'h80, 32'h0);
    apb(1'b1, UEA_OFS_POWER_CTRL, 32'h40);
    rchk(UEA_OFS_SERIAL_CTRL, 32'h80, 32'h80);
    apb(1'b1, UEA_OFS_SERIAL_CTRL, 32'h50);
    rchk(UEA_OFS_SERIAL_CTRL, 32'h80, 32'h0);
    // The receive flag moves from the ninth bit to the stop bit.
    timed(1'b0);
    timed(1'b1);
    // Address recognition in modes 3 and 1.
    apb(1'b1, UEA_OFS_POWER_CTRL, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      e = TBL[i];
      apb(1'b1, UEA_OFS_SERIAL_CTRL, {24'h0, e[35:28]});
      apb(1'b1, UEA_OFS_SLAVE_ADDR, {24'h0, e[27:20]});
      apb(1'b1, UEA_OFS_SLAVE_MASK, {24'h0, e[19:12]});
      node_u.send(e[11:4], e[3], e[2], e[1]);
      rchk(UEA_OFS_SERIAL_CTRL, 32'h1, {31'h0, e[0]});
      if (e[0] == 1'b1)
      begin
        rchk(UEA_OFS_RX_DATA, 32'hFF, {24'h0, e[11:4]});
      end
      apb(1'b1, UEA_OFS_SERIAL_CTRL, {24'h0, e[35:28]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
